// ===== core/ebws_defines.vh
// Constants for the external bus wait-state and bank-switch block.
// Assumes a 16-bit register port per subsystem and one machine clock.
//
// Contract
// - External bus cycles stretch by programmable waits, up to fourteen in total.
// - Wait configuration comes from the subsystem that arbitration grants the bus.
// - Low fifteen config bits hold five 3-bit base counts, one per range.
// - Multiplier bit 0 clear keeps base counts; set doubles them, fourteen at most.
// - Reset loads every range field with 111 and the multiplier with 0.
// - Config bit 15 selects the extended program range, reset value 0.
// - Bits 14..12 give base waits for all I/O space accesses.
// - Bits 11..9 give base waits for data accesses at 8000..FFFF.
// - Bits 8..6 give base waits for data accesses at 0000..7FFF.
// - Bits 5..3 cover program x8000..xFFFF when select clear; unused when set.
// - Bits 2..0 cover program x0000..x7FFF, or 00000..7FFFF when select set.
// - Multiplier register bits 15..1 read zero and ignore writes.
// - Crossing a bank inside program or data space adds one idle cycle.
// - Program to data, or program page change, adds one idle cycle.
// - Bank size comes from the owning subsystem's bank control register.
// - Four-bit bank mask on address bits 15..12, reset 1111 for 4K banks.
// - Read turnaround bit, reset 1, adds a cycle between data and program reads.
`ifndef EBWS_DEFINES_VH
`define EBWS_DEFINES_VH

`define EBWS_OFF_RANGE_CFG  8'h28
`define EBWS_OFF_BANK_CTRL  8'h29
`define EBWS_OFF_MULT_CTRL  8'h2b
`define EBWS_OFF_STATUS     8'h2c

`define EBWS_RANGE_CFG_RST  16'h7fff
`define EBWS_MULT_CTRL_RST  1'b0
`define EBWS_BANK_MASK_RST  4'hf
`define EBWS_READ_TURN_RST  1'b1

`define EBWS_EXT_PROG_BIT   15
`define EBWS_IO_LSB         12
`define EBWS_DHI_LSB        9
`define EBWS_DLO_LSB        6
`define EBWS_PHI_LSB        3
`define EBWS_PLO_LSB        0
`define EBWS_MULT_BIT       0
`define EBWS_BANK_LSB       12
`define EBWS_READ_TURN_BIT  11

`define EBWS_SP_PROG        2'b00
`define EBWS_SP_DATA        2'b01
`define EBWS_SP_IO          2'b10

`define EBWS_TURN_CYCLES    1

`endif

// ===== core/ebws_sub_regs.v
// One subsystem's wait-state and bank-switch control registers.
// Assumes one-cycle read and write strobes, never both at once.
`timescale 1ns/1ps
`include "ebws_defines.vh"

module ebws_sub_regs (
   input  wire        clk,
   input  wire        rst,
   input  wire [7:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [15:0] stat_in,
   output wire [15:0] reg_rdata,
   output wire [15:0] range_cfg,
   output wire        mult_bit,
   output wire [3:0]  bank_mask,
   output wire        read_turn
);

   reg [15:0] range_cfg_reg;
   reg        mult_reg;
   reg [3:0]  bank_mask_reg;
   reg        read_turn_reg;
   reg [15:0] rdata_reg;

   assign reg_rdata = rdata_reg;
   assign range_cfg = range_cfg_reg;
   assign mult_bit  = mult_reg;
   assign bank_mask = bank_mask_reg;
   assign read_turn = read_turn_reg;

   always @(posedge clk) begin
      if (rst) begin
         range_cfg_reg <= `EBWS_RANGE_CFG_RST;
         mult_reg      <= `EBWS_MULT_CTRL_RST;
         bank_mask_reg <= `EBWS_BANK_MASK_RST;
         read_turn_reg <= `EBWS_READ_TURN_RST;
         rdata_reg     <= 16'h0000;
      end else begin
         if (reg_wr) begin
            if (reg_addr == `EBWS_OFF_RANGE_CFG) begin
               range_cfg_reg <= reg_wdata;
            end else if (reg_addr == `EBWS_OFF_MULT_CTRL) begin
               mult_reg <= reg_wdata[`EBWS_MULT_BIT];
            end else if (reg_addr == `EBWS_OFF_BANK_CTRL) begin
               bank_mask_reg <= reg_wdata[`EBWS_BANK_LSB +: 4];
               read_turn_reg <= reg_wdata[`EBWS_READ_TURN_BIT];
            end
         end
         // Data stand only in the cycle after the read strobe
         rdata_reg <= 16'h0000;
         if (reg_rd) begin
            if (reg_addr == `EBWS_OFF_RANGE_CFG) begin
               rdata_reg <= range_cfg_reg;
            end else if (reg_addr == `EBWS_OFF_MULT_CTRL) begin
               rdata_reg <= {15'h0000, mult_reg};
            end else if (reg_addr == `EBWS_OFF_BANK_CTRL) begin
               rdata_reg <= {bank_mask_reg, read_turn_reg, 11'h000};
            end else if (reg_addr == `EBWS_OFF_STATUS) begin
               rdata_reg <= stat_in;
            end
         end
      end
   end

endmodule // ebws_sub_regs

// ===== core/ebws_wait_gen.v
// External bus wait-state generator with bank-switch turnaround insertion.
// Assumes access requests and the bus grant come from logic on clk.
`timescale 1ns/1ps
`include "ebws_defines.vh"

module ebws_wait_gen (
   input  wire        clk,
   input  wire        rst,
   input  wire [7:0]  a_reg_addr,
   input  wire [15:0] a_reg_wdata,
   input  wire        a_reg_wr,
   input  wire        a_reg_rd,
   output wire [15:0] a_reg_rdata,
   input  wire [7:0]  b_reg_addr,
   input  wire [15:0] b_reg_wdata,
   input  wire        b_reg_wr,
   input  wire        b_reg_rd,
   output wire [15:0] b_reg_rdata,
   input  wire        grant_b,
   input  wire        acc_req,
   input  wire [1:0]  acc_space,
   input  wire [18:0] acc_addr,
   input  wire        acc_read,
   output wire        acc_ready,
   output wire        acc_done,
   output wire        ext_cycle,
   output wire        ext_turn,
   output wire [1:0]  ext_space,
   output wire [18:0] ext_addr,
   output wire        ext_read,
   output wire [3:0]  wait_count
);

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_TURN = 2'b01;
   localparam [1:0] ST_BUS  = 2'b10;

   // Packed per-subsystem buses, index 0 is subsystem A
   wire [15:0] sub_addr;
   wire [31:0] sub_wdata;
   wire [1:0]  sub_wr;
   wire [1:0]  sub_rd;
   wire [31:0] sub_rdata;
   wire [31:0] sub_stat;
   wire [31:0] sub_cfg;
   wire [1:0]  sub_mult;
   wire [7:0]  sub_mask;
   wire [1:0]  sub_rturn;

   reg  [1:0]  state_reg;
   reg         ready_reg;
   reg         done_reg;
   reg         cycle_reg;
   reg         turn_reg;
   reg  [1:0]  space_reg;
   reg  [18:0] addr_reg;
   reg         read_reg;
   reg  [3:0]  cnt_reg;
   reg  [3:0]  total_reg;
   reg         prev_valid_reg;
   reg  [1:0]  prev_space_reg;
   reg  [18:0] prev_addr_reg;
   reg         prev_read_reg;

   reg  [15:0] own_cfg;
   reg         own_mult;
   reg  [3:0]  own_mask;
   reg         own_rturn;
   reg  [2:0]  base_sel;
   reg  [3:0]  waits_next;
   reg         turn_next;

   wire        take;

   assign sub_addr  = {b_reg_addr, a_reg_addr};
   assign sub_wdata = {b_reg_wdata, a_reg_wdata};
   assign sub_wr    = {b_reg_wr, a_reg_wr};
   assign sub_rd    = {b_reg_rd, a_reg_rd};
   assign a_reg_rdata = sub_rdata[15:0];
   assign b_reg_rdata = sub_rdata[31:16];

   // Status word: bit 5 owner, bit 4 busy, bits 3..0 last wait total
   assign sub_stat[15:0]  = {10'h000, ~grant_b, ~ready_reg, total_reg};
   assign sub_stat[31:16] = {10'h000, grant_b, ~ready_reg, total_reg};

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_sub
         ebws_sub_regs u_regs (
            .clk       (clk),
            .rst       (rst),
            .reg_addr  (sub_addr[g*8 +: 8]),
            .reg_wdata (sub_wdata[g*16 +: 16]),
            .reg_wr    (sub_wr[g]),
            .reg_rd    (sub_rd[g]),
            .stat_in   (sub_stat[g*16 +: 16]),
            .reg_rdata (sub_rdata[g*16 +: 16]),
            .range_cfg (sub_cfg[g*16 +: 16]),
            .mult_bit  (sub_mult[g]),
            .bank_mask (sub_mask[g*4 +: 4]),
            .read_turn (sub_rturn[g])
         );
      end
   endgenerate

   // Picks the 3-bit base count for one access
   function [2:0] pick_base;
      input [15:0] cfg;
      input [1:0]  sp;
      input [18:0] ad;
      begin
         if (sp == `EBWS_SP_IO) begin
            pick_base = cfg[`EBWS_IO_LSB +: 3];
         end else if (sp == `EBWS_SP_DATA) begin
            if (ad[15]) begin
               pick_base = cfg[`EBWS_DHI_LSB +: 3];
            end else begin
               pick_base = cfg[`EBWS_DLO_LSB +: 3];
            end
         end else if (cfg[`EBWS_EXT_PROG_BIT]) begin
            // Extended range: the low program field covers the whole space
            pick_base = cfg[`EBWS_PLO_LSB +: 3];
         end else if (ad[15]) begin
            pick_base = cfg[`EBWS_PHI_LSB +: 3];
         end else begin
            pick_base = cfg[`EBWS_PLO_LSB +: 3];
         end
      end
   endfunction

   // Decides whether an idle bus cycle must precede this access
   function need_turn;
      input        pv;
      input [1:0]  ps;
      input [18:0] pa;
      input        pr;
      input [1:0]  cs;
      input [18:0] ca;
      input        cr;
      input [3:0]  m;
      input        rt;
      begin
         need_turn = 1'b0;
         if (pv) begin
            if ((ps == cs) && (cs != `EBWS_SP_IO) &&
                ((pa[15:12] & m) != (ca[15:12] & m))) begin
               need_turn = 1'b1;
            end
            if ((ps == `EBWS_SP_PROG) && (cs == `EBWS_SP_PROG) &&
                (pa[18:16] != ca[18:16])) begin
               need_turn = 1'b1;
            end
            if ((ps == `EBWS_SP_PROG) && (cs == `EBWS_SP_DATA)) begin
               need_turn = 1'b1;
            end
            if (rt && pr && cr && (ps == `EBWS_SP_DATA) &&
                (cs == `EBWS_SP_PROG)) begin
               need_turn = 1'b1;
            end
         end
      end
   endfunction

   // Configuration of whichever subsystem holds the bus
   always @* begin
      if (grant_b) begin
         own_cfg   = sub_cfg[31:16];
         own_mult  = sub_mult[1];
         own_mask  = sub_mask[7:4];
         own_rturn = sub_rturn[1];
      end else begin
         own_cfg   = sub_cfg[15:0];
         own_mult  = sub_mult[0];
         own_mask  = sub_mask[3:0];
         own_rturn = sub_rturn[0];
      end
      base_sel = pick_base(own_cfg, acc_space, acc_addr);
      if (own_mult) begin
         waits_next = {base_sel, 1'b0};
      end else begin
         waits_next = {1'b0, base_sel};
      end
      turn_next = need_turn(prev_valid_reg, prev_space_reg, prev_addr_reg,
                            prev_read_reg, acc_space, acc_addr, acc_read,
                            own_mask, own_rturn);
   end

   assign take = acc_req & ready_reg;

   assign acc_ready  = ready_reg;
   assign acc_done   = done_reg;
   assign ext_cycle  = cycle_reg;
   assign ext_turn   = turn_reg;
   assign ext_space  = space_reg;
   assign ext_addr   = addr_reg;
   assign ext_read   = read_reg;
   assign wait_count = total_reg;

   // Bus cycle sequencer: optional idle cycle, then 1 + waits strobe cycles
   always @(posedge clk) begin
      if (rst) begin
         state_reg      <= ST_IDLE;
         ready_reg      <= 1'b1;
         done_reg       <= 1'b0;
         cycle_reg      <= 1'b0;
         turn_reg       <= 1'b0;
         space_reg      <= 2'b00;
         addr_reg       <= 19'h0_0000;
         read_reg       <= 1'b0;
         cnt_reg        <= 4'h0;
         total_reg      <= 4'h0;
         prev_valid_reg <= 1'b0;
         prev_space_reg <= 2'b00;
         prev_addr_reg  <= 19'h0_0000;
         prev_read_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (take) begin
                  ready_reg <= 1'b0;
                  space_reg <= acc_space;
                  addr_reg  <= acc_addr;
                  read_reg  <= acc_read;
                  cnt_reg   <= waits_next;
                  total_reg <= waits_next;
                  if (turn_next) begin
                     // Lets the last device release the bus before the next drives it
                     turn_reg  <= 1'b1;
                     state_reg <= ST_TURN;
                  end else begin
                     cycle_reg <= 1'b1;
                     state_reg <= ST_BUS;
                  end
               end
            end
            ST_TURN: begin
               turn_reg  <= 1'b0;
               cycle_reg <= 1'b1;
               state_reg <= ST_BUS;
            end
            ST_BUS: begin
               if (cnt_reg == 4'h0) begin
                  cycle_reg      <= 1'b0;
                  done_reg       <= 1'b1;
                  ready_reg      <= 1'b1;
                  prev_valid_reg <= 1'b1;
                  prev_space_reg <= space_reg;
                  prev_addr_reg  <= addr_reg;
                  prev_read_reg  <= read_reg;
                  state_reg      <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               ready_reg <= 1'b1;
               cycle_reg <= 1'b0;
               turn_reg  <= 1'b0;
            end
         endcase
      end
   end

endmodule // ebws_wait_gen

// ===== bench/ebws_wait_gen_sva.sv
// Port assertions for the wait-state generator.
// Assumes it is bound to ebws_wait_gen and that all ports share clk.
`timescale 1ns/1ps
module ebws_wait_gen_sva (
   input logic        clk,
   input logic        rst,
   input logic        acc_req,
   input logic        acc_ready,
   input logic        acc_done,
   input logic        ext_cycle,
   input logic        ext_turn,
   input logic [3:0]  wait_count,
   input logic        a_reg_rd,
   input logic [15:0] a_reg_rdata
);
   logic [4:0] cnt_reg;
   // Length of the running stretched cycle, zero between cycles
   always @(posedge clk) begin
      if (rst)
         cnt_reg <= 5'h00;
      else
         cnt_reg <= ext_cycle ? cnt_reg + 5'h01 : 5'h00;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_take;
      acc_req && acc_ready;
   endsequence
   sequence s_end;
      $fell(ext_cycle);
   endsequence
   chk_wait_max: assert property (wait_count <= 4'he)
      else $error("wait total above fourteen");
   chk_take_busy: assert property (s_take |=> !acc_ready && (ext_cycle ^ ext_turn))
      else $error("taken access did not start");
   chk_take_bound: assert property (s_take |-> ##[2:17] acc_done)
      else $error("access not completed in time");
   chk_turn_one: assert property (ext_turn |=> ext_cycle && !ext_turn)
      else $error("turnaround not a single cycle");
   chk_span_len: assert property (s_end |-> cnt_reg == {1'b0, wait_count} + 5'h01)
      else $error("stretched cycle length differs from wait total");
   chk_end_done: assert property (s_end |-> acc_done && acc_ready)
      else $error("no completion after stretched cycle");
   chk_done_one: assert property (acc_done |=> !acc_done)
      else $error("completion longer than one cycle");
   chk_rdata_idle: assert property (!$past(a_reg_rd) |-> a_reg_rdata == 16'h0000)
      else $error("read data outside answer cycle");
endmodule // ebws_wait_gen_sva

bind ebws_wait_gen ebws_wait_gen_sva chk_u (
   .clk(clk), .rst(rst), .acc_req(acc_req), .acc_ready(acc_ready),
   .acc_done(acc_done), .ext_cycle(ext_cycle), .ext_turn(ext_turn),
   .wait_count(wait_count), .a_reg_rd(a_reg_rd), .a_reg_rdata(a_reg_rdata)
);

// ===== bench/ebws_ext_mem.sv
// Behavioural slow off-chip memory on the stretched bus cycle.
// Assumes the device selects it while ext_cycle is high on clk.
`timescale 1ns/1ps
module ebws_ext_mem (
   input  logic       clk,
   input  logic       rst,
   input  logic       ext_cycle,
   output logic [4:0] held_len
);
   logic [4:0] cnt_reg;
   // Cycles granted to answer, counted while ext_cycle stays high
   assign held_len = cnt_reg;
   always @(posedge clk) begin
      if (rst)
         cnt_reg <= 5'h00;
      else
         cnt_reg <= ext_cycle ? cnt_reg + 5'h01 : 5'h00;
   end
endmodule // ebws_ext_mem

// ===== bench/tb_ebws_wait_gen.sv
// Self-checking random bench for the wait-state generator.
// Assumes the checker is bound in and one 40 MHz clock.
`timescale 1ns/1ps
module tb_ebws_wait_gen;
   logic        clk, rst, grant_b, acc_req, acc_read, pv, pr;
   logic [7:0]  a_reg_addr, b_reg_addr;
   logic [15:0] a_reg_wdata, b_reg_wdata, a_reg_rdata, b_reg_rdata;
   logic        a_reg_wr, a_reg_rd, b_reg_wr, b_reg_rd;
   logic [1:0]  acc_space, ext_space, ps, sp;
   logic [18:0] acc_addr, ext_addr, pa;
   logic        acc_ready, acc_done, ext_cycle, ext_turn, ext_read;
   logic [3:0]  wait_count;
   logic [4:0]  held_len;
   logic [15:0] cfg [2];
   logic [15:0] bsc [2];
   logic        mlt [2];
   logic [7:0]  adt [4] = '{8'h28, 8'h29, 8'h2b, 8'h00};
   logic [31:0] r;
   integer      seed, i;
   integer      n_fail = 0;
   integer      n_tests = 0;
   ebws_wait_gen dut_u (
      .clk(clk), .rst(rst), .a_reg_addr(a_reg_addr), .a_reg_wdata(a_reg_wdata),
      .a_reg_wr(a_reg_wr), .a_reg_rd(a_reg_rd), .a_reg_rdata(a_reg_rdata),
      .b_reg_addr(b_reg_addr), .b_reg_wdata(b_reg_wdata), .b_reg_wr(b_reg_wr),
      .b_reg_rd(b_reg_rd), .b_reg_rdata(b_reg_rdata), .grant_b(grant_b),
      .acc_req(acc_req), .acc_space(acc_space), .acc_addr(acc_addr),
      .acc_read(acc_read), .acc_ready(acc_ready), .acc_done(acc_done),
      .ext_cycle(ext_cycle), .ext_turn(ext_turn), .ext_space(ext_space),
      .ext_addr(ext_addr), .ext_read(ext_read), .wait_count(wait_count));
   ebws_ext_mem mem_u (.clk(clk), .rst(rst), .ext_cycle(ext_cycle), .held_len(held_len));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] mv(input logic b, input logic [7:0] ad);
      mv = ad == 8'h28 ? cfg[b] : ad == 8'h29 ? bsc[b] : ad == 8'h2b ? {15'h0, mlt[b]} : 16'h0;
   endfunction
   // Base count picked by space and address, then doubled if asked
   function automatic logic [15:0] exp_wait(input logic g, input logic [1:0] s, input logic [18:0] ad);
      logic [2:0] b;
      if (s == 2'h2) b = cfg[g][14:12];
      else if (s == 2'h1) b = ad[15] ? cfg[g][11:9] : cfg[g][8:6];
      else b = (!cfg[g][15] && ad[15]) ? cfg[g][5:3] : cfg[g][2:0];
      exp_wait = mlt[g] ? {12'h0, b, 1'b0} : {13'h0, b};
   endfunction
   // History is shared by both owners; mask and read bit come from the owner
   function automatic logic [15:0] exp_turn(input logic g, input logic [1:0] s,
                                            input logic [18:0] ad, input logic rd);
      logic [3:0] m;
      m = bsc[g][15:12];
      exp_turn = 16'h0;
      if (pv && s == ps && s != 2'h2 && (ad[15:12] & m) != (pa[15:12] & m)) exp_turn = 16'h1;
      if (pv && s == 2'h0 && ps == 2'h0 && ad[18:16] != pa[18:16]) exp_turn = 16'h1;
      if (pv && ps == 2'h0 && s == 2'h1) exp_turn = 16'h1;
      if (pv && ps == 2'h1 && pr && s == 2'h0 && rd && bsc[g][11]) exp_turn = 16'h1;
   endfunction
   task automatic reset_all();
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      cfg = '{16'h7fff, 16'h7fff};
      bsc = '{16'hf800, 16'hf800};
      mlt = '{1'b0, 1'b0};
      pv = 1'b0;
   endtask
   task automatic rg(input logic b, input logic w, input logic [7:0] ad, input logic [15:0] d);
      a_reg_addr <= ad;
      b_reg_addr <= ad;
      a_reg_wdata <= d;
      b_reg_wdata <= d;
      a_reg_wr <= w & !b;
      a_reg_rd <= !w & !b;
      b_reg_wr <= w & b;
      b_reg_rd <= !w & b;
      @(posedge clk);
      #1;
      {a_reg_wr, a_reg_rd, b_reg_wr, b_reg_rd} <= 4'h0;
      if (!w) check(b ? b_reg_rdata : a_reg_rdata, d);
      else if (ad == 8'h28) cfg[b] = d;
      else if (ad == 8'h2b) mlt[b] = d[0];
      else if (ad == 8'h29) bsc[b] = d & 16'hf800;
      @(posedge clk);
      #1;
   endtask
   task automatic ac(input logic g, input logic [1:0] s, input logic [18:0] ad, input logic rd);
      logic [15:0] w, t;
      integer n;
      w = exp_wait(g, s, ad);
      t = exp_turn(g, s, ad, rd);
      grant_b <= g;
      acc_space <= s;
      acc_addr <= ad;
      acc_read <= rd;
      acc_req <= 1'b1;
      @(posedge clk);
      #1;
      acc_req <= 1'b0;
      check({15'h0, ext_turn}, t);
      check({10'h0, ext_read, ext_space, ext_addr[18:16]}, {10'h0, rd, s, ad[18:16]});
      check(ext_addr[15:0], ad[15:0]);
      n = 1;
      while (acc_done !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(n[15:0], w + 16'h2 + t);
      check({12'h0, wait_count}, w);
      check({11'h0, held_len}, w + 16'h1);
      {pv, ps, pa, pr} = {1'b1, s, ad, rd};
   endtask
   task automatic results();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      {a_reg_addr, a_reg_wdata, a_reg_wr, a_reg_rd, b_reg_addr, b_reg_wdata} = '0;
      {b_reg_wr, b_reg_rd, grant_b, acc_req, acc_space, acc_addr, acc_read} = '0;
      rst = 1'b1;
      seed = 11;
      reset_all();
      for (i = 0; i < 8; i++) rg(i[2], 1'b0, adt[i[1:0]], mv(i[2], adt[i[1:0]]));
      ac(1'b0, 2'h1, 19'h0_9000, 1'b1);
      // Status: owner flag, idle, last wait total of seven
      rg(1'b0, 1'b0, 8'h2c, 16'h0027);
      rg(1'b1, 1'b0, 8'h2c, 16'h0007);
      rg(1'b0, 1'b1, 8'h2b, 16'hffff);
      rg(1'b0, 1'b0, 8'h2b, mv(1'b0, 8'h2b));
      ac(1'b0, 2'h2, 19'h0_1234, 1'b0);
      rg(1'b0, 1'b1, 8'h28, 16'h8038);
      ac(1'b0, 2'h0, 19'h0_8000, 1'b1);
      ac(1'b0, 2'h0, 19'h1_8000, 1'b1);
      ac(1'b0, 2'h1, 19'h0_8000, 1'b1);
      ac(1'b0, 2'h0, 19'h1_8000, 1'b1);
      rg(1'b0, 1'b1, 8'h29, 16'h0000);
      ac(1'b0, 2'h1, 19'h0_1000, 1'b1);
      ac(1'b0, 2'h0, 19'h1_0000, 1'b1);
      // Random mix of register writes and accesses from either owner
      for (i = 0; i < 80; i++) begin
         r = $random(seed);
         sp = r[5:4] == 2'h3 ? 2'h1 : r[5:4];
         if (r[1:0] == 2'h0) begin
            rg(r[2], 1'b1, adt[r[4:3]], r[31:16]);
            rg(r[2], 1'b0, adt[r[4:3]], mv(r[2], adt[r[4:3]]));
         end
         else ac(r[2], sp, {sp == 2'h0 ? r[10:8] : 3'h0, r[31:16]}, r[7]);
      end
      reset_all();
      rg(1'b1, 1'b0, 8'h28, mv(1'b1, 8'h28));
      ac(1'b1, 2'h1, 19'h0_9000, 1'b1);
      results();
   end
   // Run needs under two thousand cycles; ten thousand means a hang
   initial begin
      #250000;
      n_fail++;
      results();
   end
endmodule // tb_ebws_wait_gen
